// ==== pkg/port_s_pkg.sv ====
package port_s_pkg;

  localparam int BUS_W   = 32;
  localparam int ADDR_W  = 12;
  localparam int PORT_W  = 4;
  localparam int PWM_N   = 3;

  // byte addresses of the register words
  localparam logic [ADDR_W-1:0] ROUTE_OFS  = 12'h0240;
  localparam logic [ADDR_W-1:0] DATA_OFS   = 12'h0248;
  localparam logic [ADDR_W-1:0] INPUT_OFS  = 12'h024C;
  localparam logic [ADDR_W-1:0] DIR_OFS    = 12'h0250;
  localparam logic [ADDR_W-1:0] REDUCE_OFS = 12'h0254;

  // route bit position per routed channel: index 0, 1, 2 = channel 0, 4, 5
  localparam int ROUTE_BIT [PWM_N] = '{0, 4, 5};

  // alternative function pins on port s
  localparam int TXD_BIT = 1;
  localparam int RXD_BIT = 0;

  // reset values
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'h00;
  localparam logic [7:0] REDUCE_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST  = 8'h00;
  localparam logic       RXD_IDLE   = 1'h1;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// ==== src/port_s_gpio_pwm_routing.sv ====
`timescale 1ns/100ps

// Overview of operation
// - route bit 5 set sends pwm channel 5 to port t pin 5, else port p.
// - route bit 4 set sends pwm channel 4 to port t pin 4, else port p.
// - route bit 0 set sends pwm channel 0 to port t pin 0, else port p.
// - route, data, direction and drive registers are readable and writable anytime.
// - unclaimed output pin drives its stored data bit.
// - data read gives stored bit where direction is 1, pin level otherwise.
// - port s bit 1 carries serial transmit output as alternative function.
// - port s bit 0 carries serial receive input as alternative function.
// - enabled serial interface overrides gpio on port s bits 1 and 0.
// - input register read always returns pin levels regardless of direction.
// - writes to the input register are ignored.
// - each direction bit selects input or output for its pin.
// - enabled serial forces pin direction; stored direction bit stays unchanged.
// - drive bit set gives reduced drive, cleared gives full drive.
// - drive bit ignored on input pins, applies to whatever function drives.
// - enabled pwm routed to port t forces that pin to output.
module port_s_gpio_pwm_routing #(
  parameter int PORT_W = port_s_pkg::PORT_W
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic [port_s_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [port_s_pkg::BUS_W-1:0]  avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [port_s_pkg::BUS_W-1:0]  avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic [PORT_W-1:0]             port_s_pin_in,
  output logic      [PORT_W-1:0]             port_s_pin_out,
  output logic      [PORT_W-1:0]             port_s_pin_oe,
  output logic      [PORT_W-1:0]             port_s_pin_reduce,
  input  wire logic                          sci_tx_en,
  input  wire logic                          sci_txd,
  input  wire logic                          sci_rx_en,
  output logic                               sci_rxd,
  input  wire logic [port_s_pkg::PWM_N-1:0]  pwm_chan_out,
  input  wire logic [port_s_pkg::PWM_N-1:0]  pwm_chan_en,
  output logic      [port_s_pkg::PWM_N-1:0]  port_t_pwm_out,
  output logic      [port_s_pkg::PWM_N-1:0]  port_t_pwm_oe,
  output logic      [port_s_pkg::PWM_N-1:0]  port_p_pwm_out,
  output logic      [port_s_pkg::PWM_N-1:0]  port_p_pwm_oe
);

  localparam int TXD = port_s_pkg::TXD_BIT;
  localparam int RXD = port_s_pkg::RXD_BIT;
  localparam int NCH = port_s_pkg::PWM_N;

  if (PORT_W < 2 || PORT_W > 8) begin : g_bad_width
    $error("PORT_W must lie between 2 and 8");
  end

  port_s_pkg::bus_state_t state_reg;

  logic [PORT_W-1:0]          data_reg;
  logic [PORT_W-1:0]          dir_reg;
  logic [PORT_W-1:0]          reduce_reg;
  logic [NCH-1:0]             route_reg;
  logic [PORT_W-1:0]          pin_sync_q;
  logic [PORT_W-1:0]          pin_out_next;
  logic [PORT_W-1:0]          pin_oe_next;
  logic [port_s_pkg::BUS_W-1:0] rd_word;
  logic                       commit;
  logic [PORT_W-1:0]          wr_data;
  logic [PORT_W-1:0]          gpio_read;
  logic                       sel_route;
  logic                       sel_data;
  logic                       sel_input;
  logic                       sel_dir;
  logic                       sel_reduce;

  pin_sync #(
    .WIDTH (PORT_W)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (port_s_pin_in),
    .sync_out (pin_sync_q)
  );

  assign sel_route  = avs_address == port_s_pkg::ROUTE_OFS;
  assign sel_data   = avs_address == port_s_pkg::DATA_OFS;
  assign sel_input  = avs_address == port_s_pkg::INPUT_OFS;
  assign sel_dir    = avs_address == port_s_pkg::DIR_OFS;
  assign sel_reduce = avs_address == port_s_pkg::REDUCE_OFS;

  // a write lands at the edge where waitrequest is seen low; only lane 0 carries data
  assign commit  = (state_reg == port_s_pkg::BUS_ACK) && avs_write && avs_byteenable[0];
  assign wr_data = avs_writedata[PORT_W-1:0];

  // bus handshake: one wait cycle, then one ready cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg       <= port_s_pkg::BUS_IDLE;
      avs_waitrequest <= 1'h1;
    end else begin
      case (state_reg)
        port_s_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            state_reg       <= port_s_pkg::BUS_ACK;
            avs_waitrequest <= 1'h0;
          end
        end
        port_s_pkg::BUS_ACK: begin
          state_reg       <= port_s_pkg::BUS_IDLE;
          avs_waitrequest <= 1'h1;
        end
        default: begin
          state_reg       <= port_s_pkg::BUS_IDLE;
          avs_waitrequest <= 1'h1;
        end
      endcase
    end
  end

  assign gpio_read = (dir_reg & data_reg) | (~dir_reg & pin_sync_q);

  always_comb begin
    rd_word = '0;
    if (sel_data) begin
      rd_word[PORT_W-1:0] = gpio_read;
    end else if (sel_input) begin
      rd_word[PORT_W-1:0] = pin_sync_q;
    end else if (sel_dir) begin
      rd_word[PORT_W-1:0] = dir_reg;
    end else if (sel_reduce) begin
      rd_word[PORT_W-1:0] = reduce_reg;
    end else if (sel_route) begin
      for (int i = 0; i < NCH; i++) begin
        rd_word[port_s_pkg::ROUTE_BIT[i]] = route_reg[i];
      end
    end
  end

  // read data sampled when the ready cycle is granted, held until the next read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (state_reg == port_s_pkg::BUS_IDLE && avs_read) begin
      avs_readdata <= rd_word;
    end
  end

  // input register has no storage, so a write to it changes nothing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_reg   <= port_s_pkg::DATA_RST[PORT_W-1:0];
      dir_reg    <= port_s_pkg::DIR_RST[PORT_W-1:0];
      reduce_reg <= port_s_pkg::REDUCE_RST[PORT_W-1:0];
    end else if (commit) begin
      if (sel_data) begin
        data_reg <= wr_data;
      end
      if (sel_dir) begin
        dir_reg <= wr_data;
      end
      if (sel_reduce) begin
        reduce_reg <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NCH; i++) begin
        route_reg[i] <= port_s_pkg::ROUTE_RST[port_s_pkg::ROUTE_BIT[i]];
      end
    end else if (commit && sel_route) begin
      for (int i = 0; i < NCH; i++) begin
        route_reg[i] <= avs_writedata[port_s_pkg::ROUTE_BIT[i]];
      end
    end
  end

  // serial overrides only the pin state, never the stored direction bit
  always_comb begin
    pin_out_next = data_reg;
    pin_oe_next  = dir_reg;
    if (sci_tx_en) begin
      pin_out_next[TXD] = sci_txd;
      pin_oe_next[TXD]  = 1'h1;
    end
    if (sci_rx_en) begin
      pin_out_next[RXD] = 1'h0;
      pin_oe_next[RXD]  = 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_s_pin_out    <= '0;
      port_s_pin_oe     <= '0;
      port_s_pin_reduce <= '0;
      sci_rxd           <= port_s_pkg::RXD_IDLE;
    end else begin
      port_s_pin_out    <= pin_out_next;
      port_s_pin_oe     <= pin_oe_next;
      port_s_pin_reduce <= reduce_reg & pin_oe_next;
      sci_rxd           <= sci_rx_en ? pin_sync_q[RXD] : port_s_pkg::RXD_IDLE;
    end
  end

  // port t direction bits live outside; only the forcing enable is produced here
  for (genvar g = 0; g < NCH; g++) begin : g_pwm
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        port_t_pwm_out[g] <= 1'h0;
        port_t_pwm_oe[g]  <= 1'h0;
        port_p_pwm_out[g] <= 1'h0;
        port_p_pwm_oe[g]  <= 1'h0;
      end else begin
        port_t_pwm_out[g] <= route_reg[g] & pwm_chan_out[g];
        port_t_pwm_oe[g]  <= route_reg[g] & pwm_chan_en[g];
        port_p_pwm_out[g] <= ~route_reg[g] & pwm_chan_out[g];
        port_p_pwm_oe[g]  <= ~route_reg[g] & pwm_chan_en[g];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  route_ch5_a: assert property (
    route_reg[2] && pwm_chan_en[2] |=> port_t_pwm_oe[2] && !port_p_pwm_oe[2]
      && port_t_pwm_out[2] == $past(pwm_chan_out[2]))
    else $error("channel 5 not routed to port t");

  route_ch4_a: assert property (
    !route_reg[1] && pwm_chan_en[1] |=> port_p_pwm_oe[1] && !port_t_pwm_oe[1]
      && port_p_pwm_out[1] == $past(pwm_chan_out[1]))
    else $error("channel 4 not routed to port p");

  route_ch0_a: assert property (
    route_reg[0] |=> port_t_pwm_out[0] == $past(pwm_chan_out[0]) && !port_p_pwm_out[0])
    else $error("channel 0 routing wrong");

  route_write_a: assert property (
    commit && sel_route |=> route_reg[2] == $past(avs_writedata[5])
      && route_reg[1] == $past(avs_writedata[4]))
    else $error("route write lost");

  gpio_drive_a: assert property (
    !sci_tx_en && dir_reg[TXD] |=> port_s_pin_oe[TXD]
      && port_s_pin_out[TXD] == $past(data_reg[TXD]))
    else $error("gpio output not driven");

  data_read_a: assert property (
    state_reg == port_s_pkg::BUS_IDLE && avs_read && sel_data
      |=> avs_readdata[PORT_W-1:0] == $past(gpio_read) && !avs_waitrequest)
    else $error("data read source wrong");

  sci_tx_a: assert property (
    sci_tx_en |=> port_s_pin_oe[TXD] && port_s_pin_out[TXD] == $past(sci_txd))
    else $error("transmit not on pin");

  sci_rx_a: assert property (
    sci_rx_en ##1 sci_rx_en |=> !port_s_pin_oe[RXD] && sci_rxd == $past(pin_sync_q[RXD]))
    else $error("receive path wrong");

  input_read_a: assert property (
    state_reg == port_s_pkg::BUS_IDLE && avs_read && sel_input
      |=> avs_readdata[PORT_W-1:0] == $past(pin_sync_q))
    else $error("input read wrong");

  input_nowrite_a: assert property (
    commit && sel_input |=> $stable(data_reg) && $stable(dir_reg)
      && $stable(reduce_reg) && $stable(route_reg))
    else $error("input write had effect");

  dir_keep_a: assert property (
    !(commit && sel_dir) |=> $stable(dir_reg))
    else $error("direction changed without write");

  reduce_input_a: assert property (
    (port_s_pin_reduce & ~port_s_pin_oe) == '0)
    else $error("reduce on input pin");

  reduce_out_a: assert property (
    reduce_reg[TXD] && sci_tx_en |=> port_s_pin_reduce[TXD])
    else $error("reduced drive missing");

  upper_zero_a: assert property (
    !avs_waitrequest && avs_read && !sel_route
      |-> avs_readdata[port_s_pkg::BUS_W-1:PORT_W] == '0)
    else $error("upper bits not zero");

  wait_bound_a: assert property (
    avs_waitrequest && (avs_read || avs_write) |=> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");

  data_read_c:  cover property (!avs_waitrequest && avs_read && sel_data);
  route_wr_c:   cover property (commit && sel_route);
  sci_tx_c:     cover property (sci_tx_en && dir_reg[TXD] == 1'h0);
  pwm_t_c:      cover property (port_t_pwm_oe[2] && port_t_pwm_out[2]);

endmodule // port_s_gpio_pwm_routing

// ==== sim/pin_world.sv ====
`timescale 1ns/100ps

module pin_world (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_lvl,
  input  wire logic       short_en,
  output logic      [3:0] pin_in
);
  // a short flips what the module drives, so the input path must see it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? (pin_out[i] ^ short_en) : ext_lvl[i];
    end
  end
endmodule // pin_world

// ==== sim/port_s_gpio_pwm_routing_bench.sv ====
`timescale 1ns/100ps

module port_s_gpio_pwm_routing_bench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  pin_red;
  logic [3:0]  ext_lvl = 4'h0;
  logic        short_en = 1'b0;
  logic        sci_tx_en = 1'b0;
  logic        sci_txd = 1'b1;
  logic        sci_rx_en = 1'b0;
  logic        sci_rxd;
  logic [2:0]  pwm_out = 3'h0;
  logic [2:0]  pwm_en = 3'h0;
  logic [2:0]  t_out;
  logic [2:0]  t_oe;
  logic [2:0]  p_out;
  logic [2:0]  p_oe;
  logic [2:0]  tsel;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [11:0] ofs [6] = '{port_s_pkg::ROUTE_OFS, port_s_pkg::DATA_OFS,
    port_s_pkg::INPUT_OFS, port_s_pkg::DIR_OFS, port_s_pkg::REDUCE_OFS, 12'h300};
  logic [7:0]  routes [3] = '{8'h31, 8'h00, 8'h10};

  always #10 mclk = ~mclk;

  port_s_gpio_pwm_routing uut (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_s_pin_in(pin_in), .port_s_pin_out(pin_out), .port_s_pin_oe(pin_oe),
    .port_s_pin_reduce(pin_red), .sci_tx_en(sci_tx_en), .sci_txd(sci_txd),
    .sci_rx_en(sci_rx_en), .sci_rxd(sci_rxd), .pwm_chan_out(pwm_out),
    .pwm_chan_en(pwm_en), .port_t_pwm_out(t_out), .port_t_pwm_oe(t_oe),
    .port_p_pwm_out(p_out), .port_p_pwm_oe(p_oe));

  pin_world pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .short_en(short_en), .pin_in(pin_in));

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // waitrequest, read data and release all belong to the same rising edge
  task xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      $display("mismatch at %0t: bus hang", $time);
      end_sim();
    end else begin
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rdata, exp);
  endtask

  task idle;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 6; k++) rd(ofs[k], 32'h0000_0000);
    xfer(port_s_pkg::DIR_OFS, 1'b1, 32'h0000_00ff);
    rd(port_s_pkg::DIR_OFS, 32'h0000_000f);
    xfer(port_s_pkg::DATA_OFS, 1'b1, 32'h0000_00fa);
    rd(port_s_pkg::DATA_OFS, 32'h0000_000a);
    idle();
    chk(pin_out, 4'ha);
    chk(pin_oe, 4'hf);
    rd(port_s_pkg::INPUT_OFS, 32'h0000_000a);
    short_en <= 1'b1;
    idle();
    rd(port_s_pkg::INPUT_OFS, 32'h0000_0005);
    rd(port_s_pkg::DATA_OFS, 32'h0000_000a);
    xfer(port_s_pkg::INPUT_OFS, 1'b1, 32'h0000_000f);
    rd(port_s_pkg::INPUT_OFS, 32'h0000_0005);
    short_en <= 1'b0;
    avs_byteenable <= 4'he;
    xfer(port_s_pkg::DATA_OFS, 1'b1, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    rd(port_s_pkg::DATA_OFS, 32'h0000_000a);
    xfer(port_s_pkg::REDUCE_OFS, 1'b1, 32'h0000_000f);
    idle();
    chk(pin_red, 4'hf);
    xfer(port_s_pkg::DIR_OFS, 1'b1, 32'h0000_0001);
    ext_lvl <= 4'h6;
    idle();
    chk(pin_red, 4'h1);
    chk(pin_oe, 4'h1);
    rd(port_s_pkg::DATA_OFS, 32'h0000_0006);
    // serial takes bits 1 and 0 even against the direction bits
    sci_tx_en <= 1'b1;
    sci_txd <= 1'b0;
    sci_rx_en <= 1'b1;
    idle();
    chk(pin_oe, 4'h2);
    chk(pin_out[1], 1'b0);
    chk(pin_red, 4'h2);
    chk(sci_rxd, 1'b0);
    sci_txd <= 1'b1;
    ext_lvl <= 4'h7;
    idle();
    chk(pin_out[1], 1'b1);
    chk(sci_rxd, 1'b1);
    rd(port_s_pkg::DIR_OFS, 32'h0000_0001);
    for (int r = 0; r < 3; r++) begin
      xfer(port_s_pkg::ROUTE_OFS, 1'b1, {24'h00_0000, routes[r]});
      rd(port_s_pkg::ROUTE_OFS, {24'h00_0000, routes[r]});
      tsel = {routes[r][5], routes[r][4], routes[r][0]};
      for (int p = 0; p < 2; p++) begin
        pwm_out <= p ? 3'h2 : 3'h5;
        pwm_en <= p ? 3'h6 : 3'h7;
        idle();
        chk(t_out & tsel, pwm_out & tsel);
        chk(p_out & ~tsel, pwm_out & ~tsel);
        chk(t_oe & tsel, pwm_en & tsel);
        chk(p_oe & ~tsel, pwm_en & ~tsel);
        chk(p_out & tsel, 3'h0);
        chk(t_oe & ~tsel, 3'h0);
      end
    end
    end_sim();
  end
endmodule // port_s_gpio_pwm_routing_bench
